// ==== src/uibp_map.svh ====
// register offsets, field positions, reset values and timing counts of the uart control block
`ifndef UIBP_MAP_SVH
`define UIBP_MAP_SVH

// byte offsets of the register words
`define UIBP_OFF_STATUS 6'h00
`define UIBP_OFF_MASK 6'h04
`define UIBP_OFF_PRELOAD_HIGH 6'h08
`define UIBP_OFF_PRELOAD_LOW 6'h0c
`define UIBP_OFF_VECTOR 6'h10
`define UIBP_OFF_INPUT_PIN 6'h14
`define UIBP_OFF_INPUT_CHANGE 6'h18
`define UIBP_OFF_AUX_CONTROL 6'h1c
`define UIBP_OFF_OUTPUT_SET 6'h20
`define UIBP_OFF_OUTPUT_CLEAR 6'h24
`define UIBP_OFF_TX_DATA 6'h28
`define UIBP_OFF_COMMAND 6'h2c
`define UIBP_OFF_EVENT_STATUS 6'h30
`define UIBP_OFF_EVENT_MASK 6'h34

// interrupt flag positions
`define UIBP_BIT_COS 7
`define UIBP_BIT_DB 2
`define UIBP_BIT_RX 1
`define UIBP_BIT_TX 0
`define UIBP_FLAG_USED 8'h87

// input change register layout
`define UIBP_BIT_CHG_COS 4
`define UIBP_CHG_FIXED 8'h0e

// command register bits
`define UIBP_BIT_CMD_TX_EN 0
`define UIBP_BIT_CMD_TX_DIS 1

// reset values
`define UIBP_RST_VECTOR 8'h0f
`define UIBP_RST_PRELOAD 16'h0000
`define UIBP_RST_MASK 8'h00

// answer on an unmapped address
`define UIBP_UNMAPPED_DATA 32'h0000_0000

// timing: change filter and the shift time of one character
`define UIBP_CLK_HZ 100000000
`define UIBP_COS_FILTER_US 25
`define UIBP_COS_FILTER_CYC ((`UIBP_COS_FILTER_US * (`UIBP_CLK_HZ / 1000000)))
`define UIBP_CHAR_BITS 10
`define UIBP_PRELOAD_MIN 16'h0002

`endif

// ==== src/uibp_pkg.sv ====
// types shared by the uart interrupt, baud and port control block
package uibp_pkg;

  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } uibp_bus_req_type;

  typedef struct packed {
    logic cos;
    logic delta_break;
    logic rx;
    logic tx;
  } uibp_flags_type;

  typedef enum logic [1:0] {
    UIBP_TX_IDLE = 2'b00,
    UIBP_TX_SHIFT = 2'b01
  } uibp_tx_state_type;

  typedef enum logic [1:0] {
    UIBP_BUS_IDLE = 2'b00,
    UIBP_BUS_ANSWER = 2'b01
  } uibp_bus_state_type;

endpackage

// ==== src/uibp_ctrl.sv ====
// uart channel control: interrupt flags and mask, baud preload, vector, cts and rts ports
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`include "uibp_map.svh"

module uibp_ctrl
  import uibp_pkg::*;
#(
  parameter int COS_FILTER_CYCLES = `UIBP_COS_FILTER_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic [5:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic CTS_PIN_IN,
  input wire logic DELTA_BREAK_IN,
  input wire logic RX_READY_IN,
  output logic RTS_N_OUT,
  output logic IRQ_OUT,
  output logic [7:0] VECTOR_OUT,
  output logic [15:0] BAUD_PRELOAD_OUT,
  output logic [7:0] TX_CHAR_OUT,
  output logic TX_CHAR_VALID_OUT
);

  // ==========================================================
  // bus request capture
  // ==========================================================
  uibp_bus_req_type req;
  uibp_bus_state_type bus_state;
  logic wr_hit;
  logic rd_hit;

  always_comb begin
    req.address = AVS_ADDRESS_IN;
    req.read = AVS_READ_IN;
    req.write = AVS_WRITE_IN;
    req.writedata = AVS_WRITEDATA_IN;
    req.byteenable = AVS_BYTEENABLE_IN;
  end

  // every access takes one wait cycle, then acts on the answer edge
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      bus_state <= UIBP_BUS_IDLE;
    end else if (bus_state == UIBP_BUS_IDLE && (req.read || req.write)) begin
      bus_state <= UIBP_BUS_ANSWER;
    end else begin
      bus_state <= UIBP_BUS_IDLE;
    end
  end

  assign wr_hit = (bus_state == UIBP_BUS_ANSWER) && req.write && req.byteenable[0];
  assign rd_hit = (bus_state == UIBP_BUS_ANSWER) && req.read;

  function automatic logic is_write_to(input logic [5:0] addr, input logic [5:0] off,
                                       input logic hit);
    is_write_to = hit && (addr == off);
  endfunction

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic cts_meta;
  logic cts_sync;
  logic db_meta;
  logic db_sync;
  logic rx_meta;
  logic rx_sync;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
      db_meta <= 1'b0;
      db_sync <= 1'b0;
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
    end else begin
      cts_meta <= CTS_PIN_IN;
      cts_sync <= cts_meta;
      db_meta <= DELTA_BREAK_IN;
      db_sync <= db_meta;
      rx_meta <= RX_READY_IN;
      rx_sync <= rx_meta;
    end
  end

  // ==========================================================
  // cts change filter and change register
  // ==========================================================
  // a level must hold for the filter time before it counts as a change
  logic cts_state;
  logic cts_started;
  logic [15:0] cos_count;
  logic cos_event;
  logic chg_cos;
  logic aux_iec;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      cts_state <= 1'b1;
      cts_started <= 1'b0;
      cos_count <= 16'h0000;
      cos_event <= 1'b0;
    end else begin
      cos_event <= 1'b0;
      if (!cts_started) begin
        cts_started <= 1'b1;
        cts_state <= cts_sync;
        cos_event <= ~cts_sync;
      end else if (cts_sync == cts_state) begin
        cos_count <= 16'h0000;
      end else if (cos_count >= 16'(COS_FILTER_CYCLES - 1)) begin
        cts_state <= cts_sync;
        cos_count <= 16'h0000;
        cos_event <= 1'b1;
      end else begin
        cos_count <= cos_count + 16'h0001;
      end
    end
  end

  // a read of the change register clears its change bit; a new change wins
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      chg_cos <= 1'b0;
    end else if (cos_event) begin
      chg_cos <= 1'b1;
    end else if (rd_hit && req.address == `UIBP_OFF_INPUT_CHANGE) begin
      chg_cos <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      aux_iec <= 1'b0;
    end else if (is_write_to(req.address, `UIBP_OFF_AUX_CONTROL, wr_hit)) begin
      aux_iec <= req.writedata[0];
    end
  end

  // ==========================================================
  // transmitter holding register
  // ==========================================================
  uibp_tx_state_type tx_state;
  logic tx_enabled;
  logic tx_empty;
  logic [15:0] baud_count;
  logic [3:0] bit_count;
  logic tx_load;

  assign tx_load = is_write_to(req.address, `UIBP_OFF_TX_DATA, wr_hit);

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      tx_enabled <= 1'b0;
    end else if (is_write_to(req.address, `UIBP_OFF_COMMAND, wr_hit)) begin
      if (req.writedata[`UIBP_BIT_CMD_TX_DIS]) begin
        tx_enabled <= 1'b0;
      end else if (req.writedata[`UIBP_BIT_CMD_TX_EN]) begin
        tx_enabled <= 1'b1;
      end
    end
  end

  // holding register hands its character to the shifter, which takes the
  // preload times ten bit slots; the shifter itself is outside this block
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      tx_state <= UIBP_TX_IDLE;
      tx_empty <= 1'b1;
      baud_count <= 16'h0000;
      bit_count <= 4'h0;
      TX_CHAR_OUT <= 8'h00;
      TX_CHAR_VALID_OUT <= 1'b0;
    end else begin
      TX_CHAR_VALID_OUT <= 1'b0;
      if (tx_load && tx_enabled && tx_empty) begin
        tx_empty <= 1'b0;
        TX_CHAR_OUT <= req.writedata[7:0];
      end
      // a load while not ready is simply dropped
      case (tx_state)
        UIBP_TX_IDLE: begin
          if (!tx_empty && tx_enabled) begin
            tx_state <= UIBP_TX_SHIFT;
            tx_empty <= 1'b1;
            TX_CHAR_VALID_OUT <= 1'b1;
            baud_count <= 16'h0000;
            bit_count <= 4'h0;
          end
        end
        UIBP_TX_SHIFT: begin
          if (!tx_enabled) begin
            tx_state <= UIBP_TX_IDLE;
          end else if (baud_count + 16'h0001 >= BAUD_PRELOAD_OUT) begin
            baud_count <= 16'h0000;
            if (bit_count == 4'(`UIBP_CHAR_BITS - 1)) begin
              tx_state <= UIBP_TX_IDLE;
            end else begin
              bit_count <= bit_count + 4'h1;
            end
          end else begin
            baud_count <= baud_count + 16'h0001;
          end
        end
        default: begin
          tx_state <= UIBP_TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // interrupt flags and mask
  // ==========================================================
  uibp_flags_type flags;
  logic [7:0] flag_byte;
  logic [7:0] mask;
  logic cos_flag;

  // cos flag is sticky and set only while aux_iec is on; the change register read clears it, a new change wins
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      cos_flag <= 1'b0;
    end else if (cos_event && aux_iec) begin
      cos_flag <= 1'b1;
    end else if (rd_hit && req.address == `UIBP_OFF_INPUT_CHANGE) begin
      cos_flag <= 1'b0;
    end
  end

  always_comb begin
    flags.cos = cos_flag;
    flags.delta_break = db_sync;
    flags.rx = rx_sync;
    flags.tx = tx_empty && tx_enabled;
    flag_byte = 8'h00;
    flag_byte[`UIBP_BIT_COS] = flags.cos;
    flag_byte[`UIBP_BIT_DB] = flags.delta_break;
    flag_byte[`UIBP_BIT_RX] = flags.rx;
    flag_byte[`UIBP_BIT_TX] = flags.tx;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      mask <= `UIBP_RST_MASK;
    end else if (is_write_to(req.address, `UIBP_OFF_MASK, wr_hit)) begin
      mask <= req.writedata[7:0] & `UIBP_FLAG_USED;
    end
  end

  // sticky event copies, cleared by writing one; set wins over clear
  logic [7:0] event_status;
  logic [7:0] event_mask;
  logic [7:0] flag_prev;
  logic [7:0] rise;

  assign rise = flag_byte & ~flag_prev;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      flag_prev <= 8'h00;
      event_status <= 8'h00;
      event_mask <= 8'h00;
    end else begin
      flag_prev <= flag_byte;
      if (is_write_to(req.address, `UIBP_OFF_EVENT_STATUS, wr_hit)) begin
        event_status <= (event_status & ~req.writedata[7:0]) | rise;
      end else begin
        event_status <= event_status | rise;
      end
      if (is_write_to(req.address, `UIBP_OFF_EVENT_MASK, wr_hit)) begin
        event_mask <= req.writedata[7:0] & `UIBP_FLAG_USED;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(flag_byte & mask) || |(event_status & event_mask);
    end
  end

  // ==========================================================
  // baud preload, vector and rts
  // ==========================================================
  logic rts_bit;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      BAUD_PRELOAD_OUT <= `UIBP_RST_PRELOAD;
      VECTOR_OUT <= `UIBP_RST_VECTOR;
    end else begin
      if (is_write_to(req.address, `UIBP_OFF_PRELOAD_HIGH, wr_hit)) begin
        BAUD_PRELOAD_OUT[15:8] <= req.writedata[7:0];
      end
      if (is_write_to(req.address, `UIBP_OFF_PRELOAD_LOW, wr_hit)) begin
        BAUD_PRELOAD_OUT[7:0] <= req.writedata[7:0];
      end
      if (is_write_to(req.address, `UIBP_OFF_VECTOR, wr_hit)) begin
        VECTOR_OUT <= req.writedata[7:0];
      end
    end
  end

  // set is tested first, but each access hits only one address, so of two writes in a sequence the later one wins
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      rts_bit <= 1'b0;
      RTS_N_OUT <= 1'b1;
    end else begin
      if (is_write_to(req.address, `UIBP_OFF_OUTPUT_SET, wr_hit) && req.writedata[0]) begin
        rts_bit <= 1'b1;
        RTS_N_OUT <= 1'b0;
      end else if (is_write_to(req.address, `UIBP_OFF_OUTPUT_CLEAR, wr_hit)
                   && req.writedata[0]) begin
        rts_bit <= 1'b0;
        RTS_N_OUT <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read data and wait request
  // ==========================================================
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = `UIBP_UNMAPPED_DATA;
    if (req.address == `UIBP_OFF_STATUS) begin
      next_readdata[7:0] = flag_byte;
    end else if (req.address == `UIBP_OFF_MASK) begin
      next_readdata[7:0] = mask;
    end else if (req.address == `UIBP_OFF_PRELOAD_HIGH
                 || req.address == `UIBP_OFF_PRELOAD_LOW) begin
      next_readdata = 32'h0000_0000;
    end else if (req.address == `UIBP_OFF_VECTOR) begin
      next_readdata[7:0] = VECTOR_OUT;
    end else if (req.address == `UIBP_OFF_INPUT_PIN) begin
      next_readdata[0] = cts_sync;
    end else if (req.address == `UIBP_OFF_INPUT_CHANGE) begin
      next_readdata[7:0] = `UIBP_CHG_FIXED;
      next_readdata[`UIBP_BIT_CHG_COS] = chg_cos;
      next_readdata[0] = cts_sync;
    end else if (req.address == `UIBP_OFF_OUTPUT_SET
                 || req.address == `UIBP_OFF_OUTPUT_CLEAR) begin
      next_readdata[0] = rts_bit;
    end else if (req.address == `UIBP_OFF_EVENT_STATUS) begin
      next_readdata[7:0] = event_status;
    end else if (req.address == `UIBP_OFF_EVENT_MASK) begin
      next_readdata[7:0] = event_mask;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      AVS_READDATA_OUT <= next_readdata;
      AVS_WAITREQUEST_OUT <= !(bus_state == UIBP_BUS_IDLE && (req.read || req.write));
    end
  end

endmodule

// ==== verif/uibp_ctrl_chk.sv ====
// port-level assertion checker for the uart control block
`timescale 1ns/1ps
`include "uibp_map.svh"
module uibp_ctrl_chk (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic [5:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic RTS_N_OUT,
  input wire logic IRQ_OUT,
  input wire logic [7:0] VECTOR_OUT,
  input wire logic [15:0] BAUD_PRELOAD_OUT,
  input wire logic TX_CHAR_VALID_OUT
);
  // ==========================================================
  // helper decode
  wire wr_ok = AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
  wire set_wr = wr_ok && AVS_ADDRESS_IN == `UIBP_OFF_OUTPUT_SET && AVS_WRITEDATA_IN[0];
  wire clr_wr = wr_ok && AVS_ADDRESS_IN == `UIBP_OFF_OUTPUT_CLEAR && AVS_WRITEDATA_IN[0];
  wire tx_wr = wr_ok && AVS_ADDRESS_IN == `UIBP_OFF_TX_DATA;
  wire vec_wr = wr_ok && AVS_ADDRESS_IN == `UIBP_OFF_VECTOR;
  wire pl_sel = AVS_ADDRESS_IN == `UIBP_OFF_PRELOAD_HIGH ||
    AVS_ADDRESS_IN == `UIBP_OFF_PRELOAD_LOW;
  wire pl_wr = wr_ok && pl_sel;
  wire pl_rd = AVS_READ_IN && pl_sel;
  wire mask_sel = AVS_ADDRESS_IN == `UIBP_OFF_MASK || AVS_ADDRESS_IN == `UIBP_OFF_EVENT_MASK;
  // sticky: leads the registered irq, so it can never lag behind a real enable
  logic mask_seen;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) mask_seen <= 1'b0;
    else if (wr_ok && mask_sel && AVS_WRITEDATA_IN[7:0] != 8'h00) mask_seen <= 1'b1;
  end
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  // ==========================================================
  // properties
  property p_rts_set; set_wr && !AVS_WAITREQUEST_OUT && $past(set_wr) |-> ##[1:2] !RTS_N_OUT;
  endproperty
  a_rts_set: assert property (p_rts_set) else $error("rts not asserted");
  property p_rts_clr; clr_wr && !AVS_WAITREQUEST_OUT && $past(clr_wr) |-> ##[1:2] RTS_N_OUT;
  endproperty
  a_rts_clr: assert property (p_rts_clr) else $error("rts not negated");
  property p_rts_cause; $changed(RTS_N_OUT) |-> $past(set_wr || clr_wr) ||
    $past(set_wr || clr_wr, 2);
  endproperty
  a_rts_cause: assert property (p_rts_cause) else $error("rts moved alone");
  property p_reset_vals; $rose(RESET_N_IN) |-> VECTOR_OUT == `UIBP_RST_VECTOR && RTS_N_OUT &&
    !IRQ_OUT && BAUD_PRELOAD_OUT == 16'h0000 && !TX_CHAR_VALID_OUT; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  property p_vec_cause; $changed(VECTOR_OUT) |-> $past(vec_wr); endproperty
  a_vec_cause: assert property (p_vec_cause) else $error("vector moved alone");
  property p_pl_cause; $changed(BAUD_PRELOAD_OUT) |-> $past(pl_wr); endproperty
  a_pl_cause: assert property (p_pl_cause) else $error("preload moved alone");
  property p_pl_read; pl_rd && $past(pl_rd) |-> AVS_READDATA_OUT == 32'h0000_0000; endproperty
  a_pl_read: assert property (p_pl_read) else $error("preload readable");
  property p_tx_pulse; TX_CHAR_VALID_OUT |=> !TX_CHAR_VALID_OUT; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx valid too long");
  property p_tx_cause; $rose(TX_CHAR_VALID_OUT) |-> $past(tx_wr) || $past(tx_wr, 2) ||
    $past(tx_wr, 3); endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx char without write");
  property p_irq_mask; !mask_seen |-> !IRQ_OUT; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with no enable");
  property p_bus_answer; (AVS_READ_IN || AVS_WRITE_IN) |-> ##[0:4] !AVS_WAITREQUEST_OUT;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus never answered");
  c_rts: cover property (set_wr && !AVS_WAITREQUEST_OUT);
  c_irq: cover property ($rose(IRQ_OUT));
  c_tx: cover property ($rose(TX_CHAR_VALID_OUT));
endmodule
bind uibp_ctrl uibp_ctrl_chk i_chk (.CLK_SYS_IN, .RESET_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN,
  .AVS_WRITE_IN, .AVS_WRITEDATA_IN, .AVS_BYTEENABLE_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT,
  .RTS_N_OUT, .IRQ_OUT, .VECTOR_OUT, .BAUD_PRELOAD_OUT, .TX_CHAR_VALID_OUT);

// ==== verif/uibp_line_model.sv ====
// line-side model: cts, break and receiver levels, catches handed-over characters
`timescale 1ns/1ps
module uibp_line_model (
  input wire logic clk_in,
  input wire logic [7:0] char_in,
  input wire logic char_valid_in,
  output logic cts_out,
  output logic break_out,
  output logic rx_ready_out
);
  int unsigned char_count;
  logic [7:0] last_char;
  // cts starts high so no start-up change event is raised
  initial begin
    cts_out = 1'b1;
    break_out = 1'b0;
    rx_ready_out = 1'b0;
    char_count = 0;
    last_char = 8'h00;
  end
  always @(posedge clk_in) begin
    if (char_valid_in === 1'b1) begin
      char_count <= char_count + 1;
      last_char <= char_in;
    end
  end
  task automatic drive(input logic cts, input logic brk, input logic rdy);
    @(posedge clk_in);
    cts_out <= cts;
    break_out <= brk;
    rx_ready_out <= rdy;
  endtask
endmodule

// ==== verif/uibp_ctrl_tb.sv ====
// self-checking bench for the uart control block
`timescale 1ns/1ps
`include "uibp_map.svh"
module uibp_ctrl_tb;
  import uibp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  uibp_bus_req_type req = '0;
  logic [31:0] rdata, rd_val;
  logic wait_req, rts_n, irq, cts, brk, rdy, tx_valid;
  logic [7:0] vector, tx_char;
  logic [15:0] preload;
  int num_errors = 0;
  int num_checks = 0;
  // {address, data bit, expected rts pin}
  logic [7:0] rts_tab [4] = '{{`UIBP_OFF_OUTPUT_SET, 2'b01}, {`UIBP_OFF_OUTPUT_SET, 2'b10},
    {`UIBP_OFF_OUTPUT_CLEAR, 2'b00}, {`UIBP_OFF_OUTPUT_CLEAR, 2'b11}};
  // {break, rx ready, mask, expected status, expected irq}
  logic [18:0] irq_tab [6] = '{{2'b00, 8'h86, 8'h01, 1'b0}, {2'b00, 8'h01, 8'h01, 1'b1},
    {2'b01, 8'h00, 8'h03, 1'b0}, {2'b01, 8'h02, 8'h03, 1'b1},
    {2'b10, 8'h02, 8'h05, 1'b0}, {2'b10, 8'h04, 8'h05, 1'b1}};
  always #5 clk_sys = ~clk_sys;
  uibp_ctrl #(.COS_FILTER_CYCLES(4)) i_dut (.CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n),
    .AVS_ADDRESS_IN(req.address), .AVS_READ_IN(req.read), .AVS_WRITE_IN(req.write),
    .AVS_WRITEDATA_IN(req.writedata), .AVS_BYTEENABLE_IN(req.byteenable),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req), .CTS_PIN_IN(cts),
    .DELTA_BREAK_IN(brk), .RX_READY_IN(rdy), .RTS_N_OUT(rts_n), .IRQ_OUT(irq),
    .VECTOR_OUT(vector), .BAUD_PRELOAD_OUT(preload), .TX_CHAR_OUT(tx_char),
    .TX_CHAR_VALID_OUT(tx_valid));
  uibp_line_model i_line (.clk_in(clk_sys), .char_in(tx_char), .char_valid_in(tx_valid),
    .cts_out(cts), .break_out(brk), .rx_ready_out(rdy));
  // ==========================================================
  // tasks
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // waitrequest and read data are taken at the rising edge, before that edge updates them
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{address: a, read: !wr, write: wr, writedata: {24'h0, d}, byteenable: be};
    @(posedge clk_sys);
    while (wait_req !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) chk(32'h0, 32'h1, "bus timeout");
    rd_val = rdata;
    req <= '0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(rd_val, {24'h0, e}, $sformatf("read %h", a));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({24'h0, vector}, {24'h0, `UIBP_RST_VECTOR}, "vector out");
    chk({16'h0, preload}, {16'h0, `UIBP_RST_PRELOAD}, "preload out");
    chk({31'h0, rts_n}, 32'h1, "rts reset");
    @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(`UIBP_OFF_VECTOR, `UIBP_RST_VECTOR);
    rd_chk(`UIBP_OFF_MASK, `UIBP_RST_MASK);
    rd_chk(`UIBP_OFF_STATUS, 8'h00);
    rd_chk(6'h3c, 8'h00);
    // software bring-up order, vector holds an autovector number
    wr(`UIBP_OFF_COMMAND, 8'h02);
    wr(`UIBP_OFF_VECTOR, 8'h40);
    wr(`UIBP_OFF_MASK, 8'h00);
    wr(`UIBP_OFF_AUX_CONTROL, 8'h00);
    wr(`UIBP_OFF_PRELOAD_HIGH, 8'h00);
    wr(`UIBP_OFF_PRELOAD_LOW, 8'h02);
    wr(`UIBP_OFF_COMMAND, 8'h01);
    settle(2);
    chk({16'h0, preload}, {16'h0, `UIBP_PRELOAD_MIN}, "preload min");
    chk({24'h0, vector}, 32'h40, "vector out");
    rd_chk(`UIBP_OFF_STATUS, 8'h01);
    bus(1'b1, `UIBP_OFF_VECTOR, 8'h99, 4'h2);
    rd_chk(`UIBP_OFF_VECTOR, 8'h40);
    wr(`UIBP_OFF_PRELOAD_HIGH, 8'h12);
    wr(`UIBP_OFF_PRELOAD_LOW, 8'h34);
    settle(2);
    chk({16'h0, preload}, 32'h1234, "preload out");
    rd_chk(`UIBP_OFF_PRELOAD_HIGH, 8'h00);
    rd_chk(`UIBP_OFF_PRELOAD_LOW, 8'h00);
    foreach (rts_tab[i]) begin
      wr(rts_tab[i][7:2], {7'h0, rts_tab[i][1]});
      settle(2);
      chk({31'h0, rts_n}, {31'h0, rts_tab[i][0]}, "rts pin");
    end
    foreach (irq_tab[i]) begin
      i_line.drive(1'b1, irq_tab[i][18], irq_tab[i][17]);
      wr(`UIBP_OFF_MASK, irq_tab[i][16:9]);
      settle(4);
      rd_chk(`UIBP_OFF_MASK, irq_tab[i][16:9]);
      rd_chk(`UIBP_OFF_STATUS, irq_tab[i][8:1]);
      chk({31'h0, irq}, {31'h0, irq_tab[i][0]}, "irq level");
    end
    i_line.drive(1'b0, 1'b0, 1'b0);
    wr(`UIBP_OFF_MASK, 8'h80);
    settle(20);
    rd_chk(`UIBP_OFF_INPUT_PIN, 8'h00);
    rd_chk(`UIBP_OFF_INPUT_CHANGE, 8'h1e);
    rd_chk(`UIBP_OFF_STATUS, 8'h01);
    wr(`UIBP_OFF_AUX_CONTROL, 8'h01);
    i_line.drive(1'b1, 1'b0, 1'b0);
    settle(20);
    rd_chk(`UIBP_OFF_STATUS, 8'h81);
    chk({31'h0, irq}, 32'h1, "cos irq");
    rd_chk(`UIBP_OFF_INPUT_PIN, 8'h01);
    rd_chk(`UIBP_OFF_INPUT_CHANGE, 8'h1f);
    rd_chk(`UIBP_OFF_STATUS, 8'h01);
    settle(3);
    chk({31'h0, irq}, 32'h0, "cos irq clear");
    rd_chk(`UIBP_OFF_EVENT_STATUS, 8'h87);
    wr(`UIBP_OFF_EVENT_STATUS, 8'h87);
    wr(`UIBP_OFF_EVENT_MASK, 8'h01);
    rd_chk(`UIBP_OFF_EVENT_STATUS, 8'h00);
    rd_chk(`UIBP_OFF_EVENT_MASK, 8'h01);
    chk({31'h0, irq}, 32'h0, "event irq idle");
    wr(`UIBP_OFF_TX_DATA, 8'ha5);
    settle(4);
    chk(32'(i_line.char_count), 32'h1, "tx count");
    chk({24'h0, i_line.last_char}, 32'ha5, "tx char");
    chk({31'h0, irq}, 32'h1, "event irq");
    wr(`UIBP_OFF_EVENT_STATUS, 8'h01);
    settle(2);
    chk({31'h0, irq}, 32'h0, "event irq clear");
    rd_chk(`UIBP_OFF_STATUS, 8'h01);
    wr(`UIBP_OFF_COMMAND, 8'h02);
    rd_chk(`UIBP_OFF_STATUS, 8'h00);
    wr(`UIBP_OFF_TX_DATA, 8'h5a);
    settle(6);
    chk(32'(i_line.char_count), 32'h1, "tx discard");
    give_verdict();
  end
endmodule
